// ---- core/byte_exec.sv ----
// one-cycle execution unit for five byte instructions with its own file registers
`timescale 1ns/1ps
module byte_exec (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr_word,
    output logic      [7:0]  w_q,
    output logic             zero_q,
    output logic             retired_q,
    output logic             unknown_q,
    output logic             file_we_q,
    output logic      [6:0]  file_addr_q,
    output logic      [7:0]  file_data_q
);
    logic [7:0]             file_mem [byte_ops_pkg::FILE_N];
    logic [7:0]             w_d;
    logic                   zero_d;
    logic                   retired_d;
    logic                   unknown_d;
    logic                   file_we_d;
    logic [6:0]             file_addr_d;
    logic [7:0]             file_data_d;
    logic [6:0]             f_addr;
    logic                   dir;
    logic [7:0]             f_val;
    logic [7:0]             lit;
    logic [7:0]             result;
    logic                   is_zero;
    logic                   known;
    logic                   sets_z;
    logic                   to_file;
    byte_ops_pkg::alu_sel_t sel;

    // 7-bit file field, direction bit, literal
    assign f_addr = instr_word[byte_ops_pkg::ADDR_W-1:0];
    assign dir    = instr_word[byte_ops_pkg::DIR_BIT];
    assign lit    = instr_word[byte_ops_pkg::LIT_MSB:0];
    assign f_val  = file_mem[f_addr];

    // decode
    always_comb begin
        sel     = byte_ops_pkg::ALU_W;
        known   = 1'b1;
        sets_z  = 1'b0;
        to_file = 1'b0;
        case (instr_word[byte_ops_pkg::OP6_MSB:byte_ops_pkg::OP6_LSB])
            byte_ops_pkg::OPC_INC: begin
                sel     = byte_ops_pkg::ALU_INC;
                sets_z  = 1'b1;
                to_file = dir;
            end
            byte_ops_pkg::OPC_OR: begin
                sel     = byte_ops_pkg::ALU_OR;
                sets_z  = 1'b1;
                to_file = dir;
            end
            byte_ops_pkg::OPC_MOVE: begin
                sel     = byte_ops_pkg::ALU_PASS;
                sets_z  = 1'b1;
                to_file = dir;
            end
            byte_ops_pkg::OPC_STORE: begin
                sel     = byte_ops_pkg::ALU_W;
                known   = dir;
                to_file = dir;
            end
            default: begin
                // literal load ignores the two don't-care bits
                if (instr_word[byte_ops_pkg::OP6_MSB:byte_ops_pkg::OP4_LSB]
                        == byte_ops_pkg::OPC_LOAD) begin
                    sel = byte_ops_pkg::ALU_LIT;
                end else begin
                    known = 1'b0;
                end
            end
        endcase
    end

    byte_alu u_alu (
        .sel     (sel),
        .w_val   (w_q),
        .f_val   (f_val),
        .lit     (lit),
        .result  (result),
        .is_zero (is_zero)
    );

    // next state: one instruction completes per cycle
    always_comb begin
        w_d         = w_q;
        zero_d      = zero_q;
        retired_d   = 1'b0;
        unknown_d   = 1'b0;
        file_we_d   = 1'b0;
        file_addr_d = file_addr_q;
        file_data_d = file_data_q;
        if (instr_valid) begin
            unknown_d = ~known;
            if (known) begin
                retired_d = 1'b1;
                if (sets_z) begin
                    zero_d = is_zero;
                end
                if (to_file) begin
                    file_we_d   = 1'b1;
                    file_addr_d = f_addr;
                    file_data_d = result;
                end else begin
                    w_d = result;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            w_q         <= byte_ops_pkg::W_RST;
            zero_q      <= byte_ops_pkg::Z_RST;
            retired_q   <= 1'b0;
            unknown_q   <= 1'b0;
            file_we_q   <= 1'b0;
            file_addr_q <= 7'h00;
            file_data_q <= 8'h00;
        end else begin
            w_q         <= w_d;
            zero_q      <= zero_d;
            retired_q   <= retired_d;
            unknown_q   <= unknown_d;
            file_we_q   <= file_we_d;
            file_addr_q <= file_addr_d;
            file_data_q <= file_data_d;
        end
    end

    // file register array, not reset
    always_ff @(posedge core_clk) begin
        if (rstn && file_we_d) begin
            file_mem[f_addr] <= result;
        end
    end

    a_increment_file_op_sum: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && sel == byte_ops_pkg::ALU_INC && !dir
        |=> w_q == $past(f_val) + 8'h01)
        else $error("increment result wrong");
    a_dir_file: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && known && to_file
        |=> file_we_q && file_addr_q == $past(f_addr) && w_q == $past(w_q))
        else $error("file destination not written");
    a_dir_work: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && known && sets_z && !dir |=> !file_we_q)
        else $error("working destination wrote file");
    a_or_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && sel == byte_ops_pkg::ALU_OR
        |=> zero_q == (($past(w_q) | $past(f_val)) == 8'h00))
        else $error("or zero flag wrong");
    a_move_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && sel == byte_ops_pkg::ALU_PASS
        |=> zero_q == ($past(f_val) == 8'h00))
        else $error("move zero flag wrong");
    a_store_flags: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && known && sel == byte_ops_pkg::ALU_W
        |=> $stable(zero_q) && file_data_q == $past(w_q) && file_we_q)
        else $error("store changed flags or data");
    a_lit_load: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && sel == byte_ops_pkg::ALU_LIT
        |=> w_q == $past(lit) && $stable(zero_q) && !file_we_q)
        else $error("literal load wrong");
    a_one_cycle: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid
        |=> retired_q == $past(known) && unknown_q == !$past(known))
        else $error("instruction did not retire in one cycle");
    a_increment_file_op_file: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && sel == byte_ops_pkg::ALU_INC && dir
        |=> file_data_q == $past(f_val) + 8'h01 && file_addr_q == $past(f_addr))
        else $error("increment to file wrong");
    a_increment_file_op_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && sel == byte_ops_pkg::ALU_INC
        |=> zero_q == (($past(f_val) + 8'h01) == 8'h00))
        else $error("increment zero flag wrong");
    a_or_work: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && sel == byte_ops_pkg::ALU_OR && !dir
        |=> w_q == ($past(w_q) | $past(f_val)))
        else $error("or result to working wrong");
    a_or_file: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && sel == byte_ops_pkg::ALU_OR && dir
        |=> file_data_q == ($past(w_q) | $past(f_val)) && file_addr_q == $past(f_addr))
        else $error("or result to file wrong");
    a_move_work: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && sel == byte_ops_pkg::ALU_PASS && !dir
        |=> w_q == $past(f_val))
        else $error("move to working wrong");
    a_move_file: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && sel == byte_ops_pkg::ALU_PASS && dir
        |=> file_data_q == $past(f_val) && file_addr_q == $past(f_addr))
        else $error("move to file wrong");
    a_store_work: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && known && sel == byte_ops_pkg::ALU_W
        |=> $stable(w_q) && file_addr_q == $past(f_addr))
        else $error("store changed working register");
    a_unknown_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && !known
        |=> unknown_q && !retired_q && !file_we_q && $stable(w_q) && $stable(zero_q))
        else $error("unknown word changed state");
    a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
        !instr_valid
        |=> !retired_q && !unknown_q && !file_we_q && $stable(w_q) && $stable(zero_q))
        else $error("idle cycle changed state");
    a_file_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && known && !to_file
        |=> $stable(file_addr_q) && $stable(file_data_q) && !file_we_q)
        else $error("working destination touched file outputs");
    a_zero_kept: assert property (@(posedge core_clk) disable iff (!rstn)
        instr_valid && known && !sets_z
        |=> $stable(zero_q))
        else $error("zero flag changed by flagless op");
    a_reset_value: assert property (@(posedge core_clk)
        !rstn
        |=> w_q == byte_ops_pkg::W_RST && zero_q == byte_ops_pkg::Z_RST && !retired_q)
        else $error("reset values wrong");
endmodule : byte_exec

// ---- pkg/byte_ops_pkg.sv ----
// constants and opcode encodings for the byte move, increment and or execution unit
// How it works
// - increment_file_op adds one to the file byte, result to destination, zero flag updated.
// - for increment, or and move, direction bit 0 sends result to working register, 1 writes the file register back; store with bit 0 is flagged unknown.
// - or_working_file_op ors working and file register, zero flag set on zero result.
// - move_file_op copies file register to destination and updates zero flag from it.
// - store_working_op writes working register to file, flags untouched, one word, one cycle.
// - load_literal_op loads the 8-bit immediate into working register, flags untouched.
package byte_ops_pkg;
    localparam int unsigned WORD_W   = 14;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned ADDR_W   = 7;
    localparam int unsigned FILE_N   = 128;
    localparam int unsigned DIR_BIT  = 7;
    localparam int unsigned LIT_MSB  = 7;
    localparam int unsigned OP6_MSB  = 13;
    localparam int unsigned OP6_LSB  = 8;
    localparam int unsigned OP4_LSB  = 10;

    localparam logic [5:0] OPC_INC   = 6'h0a;
    localparam logic [5:0] OPC_OR    = 6'h04;
    localparam logic [5:0] OPC_MOVE  = 6'h08;
    localparam logic [5:0] OPC_STORE = 6'h00;
    localparam logic [3:0] OPC_LOAD  = 4'hc;

    localparam logic [7:0] W_RST     = 8'h00;
    localparam logic       Z_RST     = 1'b0;

    typedef enum logic [4:0] {
        ALU_INC  = 5'h01,
        ALU_OR   = 5'h02,
        ALU_PASS = 5'h04,
        ALU_W    = 5'h08,
        ALU_LIT  = 5'h10
    } alu_sel_t;
endpackage : byte_ops_pkg

// ---- core/byte_alu.sv ----
// combinational byte datapath: result select and zero detect
`timescale 1ns/1ps
module byte_alu (
    input  wire byte_ops_pkg::alu_sel_t sel,
    input  wire logic [7:0]             w_val,
    input  wire logic [7:0]             f_val,
    input  wire logic [7:0]             lit,
    output logic      [7:0]             result,
    output logic                        is_zero
);
    always_comb begin
        case (sel)
            byte_ops_pkg::ALU_INC:  result = f_val + 8'h01;
            byte_ops_pkg::ALU_OR:   result = w_val | f_val;
            byte_ops_pkg::ALU_PASS: result = f_val;
            byte_ops_pkg::ALU_W:    result = w_val;
            byte_ops_pkg::ALU_LIT:  result = lit;
            default:                result = w_val;
        endcase
        is_zero = (result == 8'h00);
    end
endmodule : byte_alu

// ---- sim/tb_top.sv ----
// self-checking testbench for the byte execution unit
`timescale 1ns/1ps
module tb_top;
    logic        core_clk    = 1'b0;
    logic        rstn        = 1'b0;
    logic        instr_valid = 1'b0;
    logic [13:0] instr_word  = 14'h0000;
    logic [7:0]  w_q;
    logic [7:0]  file_data_q;
    logic [6:0]  file_addr_q;
    logic        zero_q;
    logic        retired_q;
    logic        unknown_q;
    logic        file_we_q;
    int          n_fail      = 0;
    int          cmp_count   = 0;
    int          cycles      = 0;

    byte_exec byte_exec_i (.core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid),
        .instr_word(instr_word), .w_q(w_q), .zero_q(zero_q), .retired_q(retired_q),
        .unknown_q(unknown_q), .file_we_q(file_we_q), .file_addr_q(file_addr_q),
        .file_data_q(file_data_q));

    always #12.5 core_clk = ~core_clk;

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic logic [13:0] enc(input logic [5:0] opc, input logic d,
                                        input logic [6:0] f);
        return {opc, d, f};
    endfunction : enc

    function automatic logic [13:0] lit(input logic [7:0] k);
        return {byte_ops_pkg::OPC_LOAD, 2'b00, k};
    endfunction : lit

    function automatic logic [13:0] store(input logic [6:0] f);
        return {byte_ops_pkg::OPC_STORE, 1'b1, f};
    endfunction : store

    // one word per call; outputs judged at the falling edge after the executing edge
    task automatic run(input logic [13:0] word, input logic [7:0] ew, input logic ez,
                       input logic ewe, input logic [7:0] ed, input logic eunk);
        instr_valid <= 1'b1;
        instr_word  <= word;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        @(negedge core_clk);
        chk("w_q", ew, w_q);
        chk("flags", {4'h0, ez, ewe, ~eunk, eunk},
            {4'h0, zero_q, file_we_q, retired_q, unknown_q});
        if (ewe) begin
            chk("file_addr_q", {1'b0, word[6:0]}, {1'b0, file_addr_q});
            chk("file_data_q", ed, file_data_q);
        end
        @(posedge core_clk);
    endtask : run

    task automatic t_literal;
        run(lit(8'hff), 8'hff, 1'b0, 1'b0, 8'h00, 1'b0);
        run(lit(8'h00), 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        $display("t_literal done");
    endtask : t_literal

    task automatic t_store;
        run(lit(8'h4f), 8'h4f, 1'b0, 1'b0, 8'h00, 1'b0);
        run(store(7'h7f), 8'h4f, 1'b0, 1'b1, 8'h4f, 1'b0);
        run(lit(8'hff), 8'hff, 1'b0, 1'b0, 8'h00, 1'b0);
        run(store(7'h05), 8'hff, 1'b0, 1'b1, 8'hff, 1'b0);
        run(lit(8'h00), 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        run(store(7'h06), 8'h00, 1'b0, 1'b1, 8'h00, 1'b0);
        $display("t_store done");
    endtask : t_store

    task automatic t_increment;
        run(enc(byte_ops_pkg::OPC_INC, 1'b1, 7'h05), 8'h00, 1'b1, 1'b1, 8'h00, 1'b0);
        run(enc(byte_ops_pkg::OPC_INC, 1'b0, 7'h05), 8'h01, 1'b0, 1'b0, 8'h00, 1'b0);
        $display("t_increment done");
    endtask : t_increment

    task automatic t_or;
        run(lit(8'h00), 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        run(enc(byte_ops_pkg::OPC_OR, 1'b0, 7'h06), 8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
        run(lit(8'h30), 8'h30, 1'b1, 1'b0, 8'h00, 1'b0);
        run(enc(byte_ops_pkg::OPC_OR, 1'b1, 7'h7f), 8'h30, 1'b0, 1'b1, 8'h7f, 1'b0);
        $display("t_or done");
    endtask : t_or

    task automatic t_move;
        run(enc(byte_ops_pkg::OPC_MOVE, 1'b1, 7'h06), 8'h30, 1'b1, 1'b1, 8'h00, 1'b0);
        run(enc(byte_ops_pkg::OPC_MOVE, 1'b0, 7'h7f), 8'h7f, 1'b0, 1'b0, 8'h00, 1'b0);
        run(14'h0005, 8'h7f, 1'b0, 1'b0, 8'h00, 1'b1);
        $display("t_move done");
    endtask : t_move

    // four words on consecutive edges; a file write is read back by the instruction after next
    task automatic t_back_to_back;
        instr_valid <= 1'b1;
        instr_word  <= lit(8'h5a);
        @(posedge core_clk);
        instr_word  <= store(7'h10);
        @(posedge core_clk);
        instr_word  <= lit(8'h00);
        @(negedge core_clk);
        chk("file_data_q", 8'h5a, file_data_q);
        chk("file_we_q", 8'h01, {7'h00, file_we_q});
        @(posedge core_clk);
        instr_word  <= enc(byte_ops_pkg::OPC_MOVE, 1'b0, 7'h10);
        @(posedge core_clk);
        instr_valid <= 1'b0;
        @(negedge core_clk);
        chk("w_q", 8'h5a, w_q);
        chk("zero_q", 8'h00, {7'h00, zero_q});
        chk("retired_q", 8'h01, {7'h00, retired_q});
        @(posedge core_clk);
        $display("t_back_to_back done");
    endtask : t_back_to_back

    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        t_literal();
        t_store();
        t_increment();
        t_or();
        t_move();
        t_back_to_back();
        summarize();
    end
endmodule : tb_top
